// File: inc/lnbi2c_consts.svh
// constants of the two-wire control link
// Notes on behaviour
// - data changes only while clock low
// - start is data falling, clock high
// - stop is data rising, clock high
// - master sends stop before each start
// - eight bits then one acknowledge slot
// - most significant bit first
// - master releases data during the slave's acknowledge; on read data it drives its own
// - addressed slave pulls data low at acknowledge
// - no acknowledge leaves data high; stop aborts
// - no acknowledge during supply undervoltage
// - master may ignore acknowledge, one clock
// - write: address, register, data, auto increment
// - read: set pointer, stop, then read
// - register reads back last written byte
`ifndef LNBI2C_CONSTS_SVH
`define LNBI2C_CONSTS_SVH
`define LNBI2C_NREG       8
`define LNBI2C_REG_RST    8'h00
`define LNBI2C_BASE_ADDR  7'h04
`define LNBI2C_SCL_HALF   8'd8
`define LNBI2C_FIFO_DEPTH 32
`endif

// File: inc/lnbi2c_pkg.sv
// types of the two-wire control link
package lnbi2c_pkg;
  typedef enum logic [1:0] {
    LNBI2C_OP_WRITE,
    LNBI2C_OP_READ
  } lnbi2c_op_t;
  typedef logic [7:0] lnbi2c_byte_t;
endpackage

// File: inc/lnbi2c_if.sv
// two-wire link between master and slave
`timescale 1ns/1ps
interface lnbi2c_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  wire  scl = ~scl_oe_n ? scl_o : 1'b1;
  wire  sda = (~sda_m_oe_n ? sda_m_o : 1'b1) & (~sda_s_oe_n ? sda_s_o : 1'b1);
  modport master (
    output scl_o, scl_oe_n, sda_m_o, sda_m_oe_n,
    input  scl, sda
  );
  modport slave (
    output sda_s_o, sda_s_oe_n,
    input  scl, sda
  );
endinterface

// File: src/lnbi2c_fifo.sv
// first in first out buffer for read data
`timescale 1ns/1ps
`include "lnbi2c_consts.svh"
module lnbi2c_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `LNBI2C_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];
  always_comb begin
    wp_d = wp_q + (AW+1)'(in_valid & in_ready);
    rp_d = rp_q + (AW+1)'(out_valid & out_ready);
  end
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
endmodule // lnbi2c_fifo

// File: src/lnbi2c_slave.sv
// slave end: register file behind the two-wire link
`timescale 1ns/1ps
`include "lnbi2c_consts.svh"
module lnbi2c_slave
  import lnbi2c_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // link
  lnbi2c_if.slave         bus,
  // straps and supply
  input  wire logic [2:0] addr_sel,
  input  wire logic       uvlo,
  // register contents
  output logic [63:0]     regs_flat
);
  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} lnbi2c_sst_t;
  lnbi2c_sst_t st_q, st_d;
  logic [1:0] scl_s, sda_s;
  logic scl_p, sda_p;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic rd_q, rd_d, ack_q, ack_d, oe_q, oe_d, dat_q, dat_d;
  logic [6:0] own_q;
  logic [1:0] uvlo_s;
  logic [2:0] sel_s0, sel_s1;
  localparam logic [6:0] own_base = `LNBI2C_BASE_ADDR;
  logic [7:0] regs [`LNBI2C_NREG];
  logic we;
  wire scl_r = scl_s[1] & ~scl_p;
  wire scl_f = ~scl_s[1] & scl_p;
  wire start = scl_s[1] & scl_p & sda_p & ~sda_s[1];
  wire stop  = scl_s[1] & scl_p & ~sda_p & sda_s[1];
  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    rd_reg = regs[a[2:0]];
  endfunction
  always_comb begin
    st_d = st_q; sh_d = sh_q; bit_d = bit_q; byte_d = byte_q;
    ptr_d = ptr_q; rd_d = rd_q; ack_d = ack_q; oe_d = oe_q;
    dat_d = dat_q; we = 1'b0;
    if (stop) begin
      st_d = ST_IDLE; oe_d = 1'b0;
    end else if (start) begin
      st_d = ST_RX; bit_d = '0; byte_d = '0; oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: ;
        ST_RX: begin
          if (scl_r) begin
            sh_d = {sh_q[6:0], sda_s[1]};
            bit_d = bit_q + 4'd1;
          end
          if (scl_f && bit_q == 4'd8) begin
            bit_d = '0;
            if (byte_q == 2'd0) begin
              ack_d = (sh_q[7:1] == own_q) && !uvlo_s[1];
              rd_d = sh_q[0];
            end else begin
              ack_d = !uvlo_s[1];
            end
            if (ack_d) begin
              oe_d = 1'b1; dat_d = 1'b0; st_d = ST_ACK;
              if (byte_q == 2'd1) ptr_d = sh_q;
              if (byte_q == 2'd2) begin
                we = 1'b1; ptr_d = ptr_q + 8'd1;
              end
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_ACK: if (scl_f) begin
          oe_d = 1'b0;
          if (byte_q == 2'd0 && rd_q) begin
            st_d = ST_TX; sh_d = rd_reg(ptr_q);
            oe_d = 1'b1; dat_d = sh_d[7]; bit_d = 4'd1;
            ptr_d = ptr_q + 8'd1;
          end else begin
            st_d = ST_RX; byte_d = (byte_q == 2'd0) ? 2'd1 : 2'd2;
          end
        end
        ST_TX: if (scl_f) begin
          if (bit_q == 4'd8) begin
            oe_d = 1'b0; st_d = ST_MACK;
          end else begin
            dat_d = sh_q[3'd7 - bit_q[2:0]]; bit_d = bit_q + 4'd1;
          end
        end
        ST_MACK: begin
          if (scl_r) ack_d = ~sda_s[1];
          if (scl_f) begin
            if (ack_q) begin
              st_d = ST_TX; sh_d = rd_reg(ptr_q);
              oe_d = 1'b1; dat_d = sh_d[7]; bit_d = 4'd1;
              ptr_d = ptr_q + 8'd1;
            end else st_d = ST_IDLE;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s  <= 2'h3;
      sda_s  <= 2'h3;
      scl_p  <= 1'b1;
      sda_p  <= 1'b1;
      // locked out until the supply flag has been seen
      uvlo_s <= 2'h3;
      sel_s0 <= 3'h0;
      sel_s1 <= 3'h0;
      st_q   <= ST_IDLE;
      sh_q   <= 8'h00;
      bit_q  <= 4'h0;
      byte_q <= 2'h0;
      ptr_q  <= 8'h00;
      rd_q   <= 1'b0;
      ack_q  <= 1'b0;
      oe_q   <= 1'b0;
      dat_q  <= 1'b1;
      own_q  <= own_base;
      for (int i = 0; i < `LNBI2C_NREG; i++) begin
        regs[i] <= `LNBI2C_REG_RST;
      end
    end else begin
      scl_s  <= {scl_s[0], bus.scl};
      sda_s  <= {sda_s[0], bus.sda};
      scl_p  <= scl_s[1];
      sda_p  <= sda_s[1];
      // supply flag and straps are asynchronous to clk
      uvlo_s <= {uvlo_s[0], uvlo};
      sel_s0 <= addr_sel;
      sel_s1 <= sel_s0;
      // strap caught while idle, so the address never moves mid-frame
      if (st_q == ST_IDLE) begin
        own_q <= {own_base[6:3], sel_s1};
      end
      st_q   <= st_d;
      sh_q   <= sh_d;
      bit_q  <= bit_d;
      byte_q <= byte_d;
      ptr_q  <= ptr_d;
      rd_q   <= rd_d;
      ack_q  <= ack_d;
      oe_q   <= oe_d;
      dat_q  <= dat_d;
      if (we) begin
        regs[ptr_q[2:0]] <= sh_q;
      end
    end
  end
  // open drain: a one is sent by letting go of the line
  assign bus.sda_s_o    = 1'b0;
  assign bus.sda_s_oe_n = ~(oe_q & ~dat_q);
  always_comb begin
    for (int i = 0; i < `LNBI2C_NREG; i++) regs_flat[i*8 +: 8] = regs[i];
  end
endmodule // lnbi2c_slave

// File: src/lnbi2c_master.sv
// master end: issues write and read transfers
`timescale 1ns/1ps
`include "lnbi2c_consts.svh"
module lnbi2c_master
  import lnbi2c_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // link
  lnbi2c_if.master        bus,
  // command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_chip,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic [5:0] cmd_len,
  input  wire logic       cmd_check_ack,
  // read data
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      rd_data,
  // status
  output logic            nack_q
);
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP, M_GAP} lnbi2c_mst_t;
  lnbi2c_mst_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d, sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] ph_q, ph_d;
  logic [5:0] left_q, left_d;
  logic [1:0] byte_q, byte_d;
  logic scl_q, scl_d, sda_q, sda_d, nack_d, rd_q, rd_d, chk_q, chk_d;
  logic [6:0] chip_q, chip_d;
  logic [7:0] reg_q, reg_d, wd_q, wd_d;
  logic rdphase_q, rdphase_d, push;
  logic [1:0] sda_s;
  logic f_ready;
  assign cmd_ready = st_q == M_IDLE;
  wire tick = cnt_q == `LNBI2C_SCL_HALF;
  lnbi2c_fifo #(.WIDTH(8), .DEPTH(`LNBI2C_FIFO_DEPTH)) u_fifo (
    .clk(clk), .rst_n(rst_n),
    .in_valid(push), .in_ready(f_ready), .in_data(sh_q),
    .out_valid(rd_valid), .out_ready(rd_ready), .out_data(rd_data)
  );
  function automatic logic [7:0] next_byte(input logic [1:0] b,
      input logic [6:0] c, input logic rp, input logic [7:0] r,
      input logic [7:0] w);
    if (b == 2'd0) next_byte = {c, rp};
    else if (b == 2'd1) next_byte = r;
    else next_byte = w;
  endfunction
  always_comb begin
    st_d      = st_q;
    cnt_d     = tick ? 8'd0 : cnt_q + 8'd1;
    sh_d      = sh_q;
    bit_d     = bit_q;
    ph_d      = ph_q;
    left_d    = left_q;
    byte_d    = byte_q;
    scl_d     = scl_q;
    sda_d     = sda_q;
    nack_d    = nack_q;
    rd_d      = rd_q;
    chk_d     = chk_q;
    chip_d    = chip_q;
    reg_d     = reg_q;
    wd_d      = wd_q;
    rdphase_d = rdphase_q;
    push      = 1'b0;
    case (st_q)
      M_IDLE: begin
        cnt_d = 8'd0;
        if (cmd_valid) begin
          chip_d    = cmd_chip;
          reg_d     = cmd_reg;
          wd_d      = cmd_wdata;
          rd_d      = cmd_read;
          left_d    = cmd_len;
          chk_d     = cmd_check_ack;
          nack_d    = 1'b0;
          rdphase_d = 1'b0;
          st_d      = M_START;
          byte_d    = 2'd0;
          ph_d      = 2'd0;
        end
      end
      M_START: if (tick) begin
        ph_d = ph_q + 2'd1;
        if (ph_q == 2'd0) begin
          scl_d = 1'b1;
          sda_d = 1'b1;
        end else if (ph_q == 2'd1) begin
          sda_d = 1'b0;
        end else begin
          // phase restarts so the stop walks all three of its steps
          ph_d  = 2'd0;
          scl_d = 1'b0;
          st_d  = M_BIT;
          bit_d = 4'd0;
          sh_d  = next_byte(byte_q, chip_q, rdphase_q, reg_q, wd_q);
          sda_d = sh_d[7];
        end
      end
      M_BIT: if (tick) begin
        if (!scl_q) begin
          // buffer full stalls the clock low before a read data bit
          scl_d = !rdphase_q || byte_q == 2'd0 || bit_q == 4'd8 || f_ready;
        end else begin
          scl_d = 1'b0;
          if (bit_q == 4'd8) begin
            bit_d = 4'd0;
            if (rdphase_q && byte_q != 2'd0) begin
              push   = 1'b1;
              left_d = left_q - 6'd1;
              if (left_q == 6'd1) begin
                st_d = M_STOP;
              end else begin
                // let go after our acknowledge: the slave drives next
                sda_d = 1'b1;
              end
            end else if (chk_q && sda_s[1]) begin
              nack_d = 1'b1;
              st_d   = M_STOP;
            end else if (byte_q == 2'd1 && rd_q) begin
              st_d = M_STOP;
            end else if (byte_q == 2'd2 || (byte_q == 2'd1 && !rdphase_q
                         && left_q == 6'd0)) begin
              left_d = left_q - 6'd1;
              byte_d = 2'd2;
              if (left_q <= 6'd1) begin
                st_d = M_STOP;
              end else begin
                sh_d  = wd_q;
                sda_d = wd_q[7];
              end
            end else begin
              // address leads to register byte, or to read data in the read phase; register to data
              byte_d = rdphase_q ? 2'd3 : byte_q + 2'd1;
              sh_d   = next_byte(byte_d, chip_q, rdphase_q, reg_q, wd_q);
              sda_d  = rdphase_q ? 1'b1 : sh_d[7];
            end
          end else begin
            bit_d = bit_q + 4'd1;
            if (rdphase_q && byte_q != 2'd0) begin
              sh_d  = {sh_q[6:0], sda_s[1]};
              sda_d = (bit_q == 4'd7) ? (left_q == 6'd1) : 1'b1;
            end else if (bit_q == 4'd7) begin
              sda_d = 1'b1;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              sda_d = sh_q[6];
            end
          end
        end
      end
      M_STOP: if (tick) begin
        ph_d = ph_q + 2'd1;
        if (ph_q == 2'd0) begin
          sda_d = 1'b0;
        end else if (ph_q == 2'd1) begin
          scl_d = 1'b1;
        end else begin
          sda_d = 1'b1;
          st_d  = M_GAP;
        end
      end
      M_GAP: if (tick) begin
        ph_d = 2'd0;
        if (rd_q && !rdphase_q && !nack_q) begin
          rdphase_d = 1'b1;
          byte_d    = 2'd0;
          st_d      = M_START;
        end else begin
          st_d = M_IDLE;
        end
      end
      default: st_d = M_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= M_IDLE;
      cnt_q     <= 8'h00;
      sh_q      <= 8'h00;
      bit_q     <= 4'h0;
      ph_q      <= 2'h0;
      left_q    <= 6'h00;
      byte_q    <= 2'h0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      nack_q    <= 1'b0;
      rd_q      <= 1'b0;
      chk_q     <= 1'b0;
      chip_q    <= 7'h00;
      reg_q     <= 8'h00;
      wd_q      <= 8'h00;
      rdphase_q <= 1'b0;
      sda_s     <= 2'h3;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      bit_q     <= bit_d;
      ph_q      <= ph_d;
      left_q    <= left_d;
      byte_q    <= byte_d;
      scl_q     <= scl_d;
      sda_q     <= sda_d;
      nack_q    <= nack_d;
      rd_q      <= rd_d;
      chk_q     <= chk_d;
      chip_q    <= chip_d;
      reg_q     <= reg_d;
      wd_q      <= wd_d;
      rdphase_q <= rdphase_d;
      // data line is asynchronous to clk while the slave drives it
      sda_s     <= {sda_s[0], bus.sda};
    end
  end
  // open drain: only ever pull low
  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe_n   = scl_q;
  assign bus.sda_m_o    = 1'b0;
  assign bus.sda_m_oe_n = sda_q;
endmodule // lnbi2c_master

// File: tb/lnbi2c_props.sv
// concurrent checks on the two-wire link between both ends
`timescale 1ns/1ps
module lnbi2c_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n,
  // supply
  input wire logic uvlo
);
  logic       scl_q, sda_q, open_q, open_d, start, stop;
  logic [9:0] edges_q, edges_d;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop  = scl && scl_q && !sda_q && sda;
  always_comb begin
    open_d  = start ? 1'b1 : (stop ? 1'b0 : open_q);
    edges_d = start ? 10'h000 : edges_q + 10'(scl && !scl_q);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      open_q  <= 1'b0;
      edges_q <= 10'h000;
    end else begin
      scl_q   <= scl;
      sda_q   <= sda;
      open_q  <= open_d;
      edges_q <= edges_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  slave_stable_a: assert property (scl && scl_q |-> $stable(sda_s_oe_n))
    else $error("slave moved data while clock high");
  edge_owner_a: assert property (
    scl && scl_q && sda != sda_q |-> $changed(sda_m_oe_n))
    else $error("frame edge not made by master");
  stop_first_a: assert property (start |-> !open_q)
    else $error("start without stop before it");
  byte_frame_a: assert property (
    stop && open_q |-> edges_q % 10'd9 == 10'd1)
    else $error("frame not whole nine-pulse bytes");
  no_clash_a: assert property (scl |-> sda_s_oe_n || sda_m_oe_n)
    else $error("both ends drive data in clock high");
  ack_low_a: assert property ($rose(scl) && !sda_s_oe_n |-> (!sda)[*8])
    else $error("acknowledge not low for high phase");
  lockout_a: assert property (uvlo |-> sda_s_oe_n)
    else $error("slave drove data under undervoltage");
  idle_quiet_a: assert property (!open_q |-> sda_s_oe_n)
    else $error("slave drove data outside a frame");
  idle_high_a: assert property (stop |=> scl[*8])
    else $error("clock not idle high after stop");
  cover property (start);
  cover property (stop && open_q);
  cover property ($rose(scl) && !sda_s_oe_n);
  cover property (uvlo && start);
endmodule // lnbi2c_props

// File: tb/tb.sv
// self-checking bench: master and slave joined over the link
`timescale 1ns/1ps
`include "lnbi2c_consts.svh"
module tb
  import lnbi2c_pkg::*;
;
  localparam logic [6:0] base = `LNBI2C_BASE_ADDR;
  logic         clk, rst_n, uvlo, cmd_valid, cmd_ready, cmd_read;
  logic         cmd_ack, rd_valid, rd_ready, nack_q;
  logic [2:0]   addr_sel;
  logic [6:0]   cmd_chip, own;
  logic [7:0]   cmd_reg, cmd_wdata, rd_data;
  logic [5:0]   cmd_len;
  logic [63:0]  regs_flat;
  logic [15:0]  lfsr_q, r;
  lnbi2c_byte_t mdl [8];
  lnbi2c_byte_t exp_q [$];
  int           num_errors, tests_run;

  lnbi2c_if lnbi2c_if_i ();
  lnbi2c_master lnbi2c_master_i (.clk(clk), .rst_n(rst_n),
    .bus(lnbi2c_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_chip(cmd_chip), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .cmd_check_ack(cmd_ack),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .nack_q(nack_q));
  lnbi2c_slave lnbi2c_slave_i (.clk(clk), .rst_n(rst_n),
    .bus(lnbi2c_if_i), .addr_sel(addr_sel), .uvlo(uvlo),
    .regs_flat(regs_flat));
  lnbi2c_props lnbi2c_props_i (.clk(clk), .rst_n(rst_n),
    .scl(lnbi2c_if_i.scl), .sda(lnbi2c_if_i.sda),
    .sda_m_oe_n(lnbi2c_if_i.sda_m_oe_n),
    .sda_s_oe_n(lnbi2c_if_i.sda_s_oe_n), .uvlo(uvlo));

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  function automatic logic [63:0] flat();
    logic [63:0] f;
    for (int i = 0; i < 8; i++) begin
      f[8*i +: 8] = mdl[i];
    end
    return f;
  endfunction

  // read bytes are drained while waiting, so a long read cannot deadlock
  task automatic run_cmd(input logic rd, input logic [6:0] chip,
      input logic [2:0] rg, input logic [7:0] wd, input logic [5:0] len,
      input logic ack, input int stall);
    int n;
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_chip  <= chip;
    cmd_reg   <= {5'h00, rg};
    cmd_wdata <= wd;
    cmd_len   <= len;
    cmd_ack   <= ack;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (rd_valid && rd_ready) begin
        check(64'(rd_data), exp_q.size() ? 64'(exp_q.pop_front()) : 'x);
      end
      if (stall > 0 && n == stall) begin
        check({62'h0, lnbi2c_if_i.scl, rd_valid}, 64'h1);
      end
      rd_ready <= (n >= stall);
      if (n > 40000) begin
        num_errors++;
        stop_test();
      end
    end while (!(cmd_ready && n > 2 && exp_q.size() == 0));
  endtask

  task automatic do_write(input logic [6:0] chip, input logic [2:0] rg,
      input logic [7:0] wd, input logic [5:0] len, input logic ack,
      input logic hit);
    run_cmd(1'b0, chip, rg, wd, len, ack, 0);
    for (int i = 0; i < len && hit; i++) begin
      mdl[(rg + i) % 8] = wd;
    end
    check(regs_flat, flat());
    if (ack) begin
      check(64'(nack_q), 64'(!hit));
    end
  endtask

  task automatic do_read(input logic [2:0] rg, input logic [5:0] len,
      input int stall);
    for (int i = 0; i < len; i++) begin
      exp_q.push_back(mdl[(rg + i) % 8]);
    end
    run_cmd(1'b1, own, rg, 8'h00, len, 1'b1, stall);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    uvlo = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_chip = 7'h00;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    cmd_len = 6'h01;
    cmd_ack = 1'b0;
    rd_ready = 1'b1;
    addr_sel = 3'h0;
    lfsr_q = 16'h0045;
    num_errors = 0;
    tests_run = 0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(regs_flat, 64'h0);
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      addr_sel <= r[2:0];
      own = {base[6:3], r[2:0]};
      @(posedge clk);
      do_write(own, r[5:3], 8'(rnd()), 6'(r[12:10]) + 6'h1,
        r[13], 1'b1);
      do_read(r[8:6], 6'(r[15:14]) + 6'h5, 0);
      do_write(own ^ 7'h08, r[2:0], 8'h5a, 6'h2, r[9], 1'b0);
    end
    // supply low: nothing lands, next command must clear the flag
    uvlo <= 1'b1;
    @(posedge clk);
    do_write(own, 3'h1, 8'ha5, 6'h3, 1'b1, 1'b0);
    uvlo <= 1'b0;
    @(posedge clk);
    do_write(own, 3'h6, 8'h3c, 6'h3, 1'b1, 1'b1);
    do_read(3'h5, 6'd40, 7000);
    stop_test();
  end
endmodule // tb
